// File: rtl/qspi_decode_regs.svh
// Behaviour
// (RL1) each opcode is held in an eight-bit instruction register before dispatch
// (RL2) a chip-select falling edge opens every frame; decoding restarts there
// (RL3) 06h sets and 04h clears the write latch in all protocols
// (RL4) 37h selects two-lane, 38h four-lane, FFh returns to single lane
// (RL5) 03h normal read and 0Bh fast read are legal in all protocols
// (RL6) 3Bh, 6Bh, BBh, EBh multi-lane reads are legal only in single lane
// (RL7) 02h write everywhere; A2h, 32h, A1h, D2h only in single lane
// (RL8) software reset needs 66h immediately followed by 99h
// (RL9) BAh hibernates, B9h enters sleep, ABh leaves sleep, in all protocols
// (RL10) 05h status read and 01h status write are legal in all protocols
// (RL11) 35h config read everywhere; 87h config write not in four-lane
// (RL12) 9Fh and 9Eh identification reads are legal in all protocols
// (RL13) C2h, C3h, C9h serial-number commands are legal in all protocols
// (RL14) 8Ch save, 8Dh restore, 8Eh/8Fh autosave on/off, all protocols
// (RL15) reserved codes C5h 1Eh C8h CEh CBh CCh CDh corrupt the configuration
// (RL16) the host clears a corrupted configuration with the 66h, 99h pair
// (RL17) the first byte after chip select falls is the opcode
// (RL18) an unknown opcode drops the rest of the frame, output stays off
// (RL19) two-lane and four-lane protocols shift over lanes one and three; the code shifts two-lane over lanes 0-1, four-lane over lanes 0-3
// (RL20) an opcode not allowed in the current protocol is treated as unknown
// (RL21) mode byte with upper nibble A keeps the opcode for the next frame
`ifndef QSPI_DECODE_REGS_SVH
`define QSPI_DECODE_REGS_SVH

`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_SET_WRITE_LATCH   8'h06
`define OP_ENTER_TWO_LANE    8'h37
`define OP_ENTER_FOUR_LANE   8'h38
`define OP_ENTER_SINGLE_LANE 8'hFF
`define OP_READ              8'h03
`define OP_FAST_READ         8'h0B
`define OP_DUAL_OUT_READ     8'h3B
`define OP_QUAD_OUT_READ     8'h6B
`define OP_DUAL_AD_READ      8'hBB
`define OP_QUAD_AD_READ      8'hEB
`define OP_WRITE             8'h02
`define OP_DUAL_DATA_WRITE   8'hA2
`define OP_QUAD_DATA_WRITE   8'h32
`define OP_DUAL_AD_WRITE     8'hA1
`define OP_QUAD_AD_WRITE     8'hD2
`define OP_RESET_ARM         8'h66
`define OP_RESET_FIRE        8'h99
`define OP_HIBERNATE_ENTRY   8'hBA
`define OP_SLEEP_ENTRY       8'hB9
`define OP_SLEEP_EXIT        8'hAB
`define OP_STATUS_READ       8'h05
`define OP_STATUS_WRITE      8'h01
`define OP_CONFIG_READ       8'h35
`define OP_CONFIG_WRITE      8'h87
`define OP_IDENT_READ        8'h9F
`define OP_FAST_IDENT_READ   8'h9E
`define OP_SERIAL_NO_WRITE   8'hC2
`define OP_SERIAL_NO_READ    8'hC3
`define OP_FAST_SERIAL_READ  8'hC9
`define OP_NV_SAVE           8'h8C
`define OP_NV_RESTORE        8'h8D
`define OP_AUTO_SAVE_ENABLE  8'h8E
`define OP_AUTO_SAVE_DISABLE 8'h8F
`define OP_RSVD_0            8'hC5
`define OP_RSVD_1            8'h1E
`define OP_RSVD_2            8'hC8
`define OP_RSVD_3            8'hCE
`define OP_RSVD_4            8'hCB
`define OP_RSVD_5            8'hCC
`define OP_RSVD_6            8'hCD
`define XIP_NIBBLE           4'hA
`define MODE_BYTE_IDX        3'h4
`define LAST_BYTE_IDX        3'h7
`define BITS_PER_BYTE        4'h8

`endif

// File: rtl/qspi_decode_pkg.sv
package qspi_decode_pkg;

    typedef enum logic [1:0] {
        PROTO_SINGLE,
        PROTO_TWO,
        PROTO_FOUR
    } proto_type;

    typedef enum logic [2:0] {
        CLS_CONTROL,
        CLS_READ,
        CLS_WRITE,
        CLS_SYSTEM,
        CLS_REGISTER,
        CLS_NV,
        CLS_RESERVED
    } cmd_class_type;

    typedef struct packed {
        cmd_class_type cls;
        logic [7:0]    opcode;
    } cmd_type;

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [7:0] rx_byte;
        logic       tog;
    } link_state_type;

endpackage

// File: rtl/sync_three_ff.sv
`timescale 1ns/1ps
module sync_three_ff #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);

    // [0..2] synchroniser chain, [3] accepted level
    logic [3:0] st_q;
    logic [3:0] st_d;

    // a change is taken only once stages two and three agree
    always_comb begin
        st_d[0] = d;
        st_d[1] = st_q[0];
        st_d[2] = st_q[1];
        st_d[3] = (st_q[1] == st_q[2]) ? st_q[2] : st_q[3];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= {4{RESET_VAL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q[3];

endmodule

// File: rtl/lane_deserializer.sv
`timescale 1ns/1ps
`include "qspi_decode_regs.svh"
module lane_deserializer
    import qspi_decode_pkg::*;
(
    input  wire logic       sck,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic [3:0] lane_in,
    input  wire proto_type  proto,
    output logic [7:0]      rx_byte,
    output logic            rx_tog
);

    link_state_type st_q;
    link_state_type st_d;
    logic           framed_q;
    logic [3:0]     step;
    logic [3:0]     sum;
    logic [2:0]     base_cnt;
    logic [7:0]     base_shift;
    logic [7:0]     shifted;

    ////////////////////////////////////////////////////////////////////////
    // frame marker: cleared while deselected, so a new frame starts at bit 0
    // without needing sck edges outside the frame
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            framed_q <= 1'b0;
        end else begin
            framed_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lane width follows the protocol; it only changes between frames
    always_comb begin
        st_d       = st_q;
        base_cnt   = framed_q ? st_q.cnt : 3'h0; // see (RL2)
        base_shift = framed_q ? st_q.shift : 8'h00;
        case (proto)
            PROTO_TWO: begin
                step    = 4'h2;
                shifted = {base_shift[5:0], lane_in[1:0]}; // see (RL19)
            end
            PROTO_FOUR: begin
                step    = 4'h4;
                shifted = {base_shift[3:0], lane_in};
            end
            default: begin
                step    = 4'h1;
                shifted = {base_shift[6:0], lane_in[0]};
            end
        endcase
        sum        = {1'b0, base_cnt} + step;
        st_d.shift = shifted;
        st_d.cnt   = sum[2:0];
        // a whole byte flips the toggle; the byte holds until the next one
        if (sum == `BITS_PER_BYTE) begin
            st_d.rx_byte = shifted;
            st_d.tog     = ~st_q.tog;
        end
    end

    // toggle survives deselect so the far side never sees a false event
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_byte = st_q.rx_byte;
    assign rx_tog  = st_q.tog;

endmodule

// File: rtl/qspi_opcode_decoder.sv
`timescale 1ns/1ps
`include "qspi_decode_regs.svh"
module qspi_opcode_decoder
    import qspi_decode_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic [3:0] lane_in,
    output cmd_type         cmd,
    output logic            cmd_valid,
    output logic [7:0]      data_byte,
    output logic            data_valid,
    output proto_type       proto,
    output logic            write_latch,
    output logic            soft_reset,
    output logic            store_req,
    output logic            recall_req,
    output logic            auto_save_en,
    output logic            sleeping,
    output logic            hibernating,
    output logic            config_bad,
    output logic            xip_active,
    output logic            out_tristate
);

    typedef struct packed {
        proto_type  proto;
        proto_type  pend;
        logic       pend_vld;
        logic       cs_prev;
        logic       tog_seen;
        logic [2:0] idx;
        logic [7:0] op;
        logic       ignore;
        logic       wel;
        logic       arm;
        logic       sleep;
        logic       hib;
        logic       autosave;
        logic       cfg_bad;
        logic       xip;
        cmd_type    cmd;
        logic       cmd_valid;
        logic [7:0] data;
        logic       data_valid;
        logic       soft_reset;
        logic       store;
        logic       recall;
    } decode_state_type;

    decode_state_type st_q;
    decode_state_type st_d;
    logic             cs_s;
    logic             tog_s;
    logic [7:0]       link_byte;
    logic             link_tog;
    logic             frame_start;
    logic             frame_end;
    logic             byte_ev;
    logic             accept;

    ////////////////////////////////////////////////////////////////////////
    // link side runs on the host's serial clock
    lane_deserializer u_link (
        .sck     (sck),
        .resetn  (resetn),
        .cs_n    (cs_n),
        .lane_in (lane_in),
        .proto   (st_q.proto),
        .rx_byte (link_byte),
        .rx_tog  (link_tog)
    );

    // chip select and the byte toggle cross into clk; the byte word itself
    // is stable for at least two sck periods after its toggle
    sync_three_ff #(.RESET_VAL(1'b1)) u_cs_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (cs_n),
        .q      (cs_s)
    );

    sync_three_ff #(.RESET_VAL(1'b0)) u_tog_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (link_tog),
        .q      (tog_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // opcode legality per protocol
    function automatic logic op_legal(input logic [7:0] op,
                                      input proto_type  p);
        logic ok;
        ok = 1'b0;
        case (op)
            `OP_CLEAR_WRITE_LATCH, `OP_SET_WRITE_LATCH: ok = 1'b1; // see (RL3)
            `OP_ENTER_TWO_LANE:    ok = (p != PROTO_TWO);   // see (RL4)
            `OP_ENTER_FOUR_LANE:   ok = (p != PROTO_FOUR);  // see (RL4)
            `OP_ENTER_SINGLE_LANE: ok = (p != PROTO_SINGLE); // see (RL4)
            `OP_READ, `OP_FAST_READ: ok = 1'b1; // see (RL5)
            `OP_DUAL_OUT_READ, `OP_QUAD_OUT_READ,
            `OP_DUAL_AD_READ, `OP_QUAD_AD_READ:
                ok = (p == PROTO_SINGLE); // see (RL6)
            `OP_WRITE: ok = 1'b1; // see (RL7)
            `OP_DUAL_DATA_WRITE, `OP_QUAD_DATA_WRITE,
            `OP_DUAL_AD_WRITE, `OP_QUAD_AD_WRITE:
                ok = (p == PROTO_SINGLE); // see (RL7)
            `OP_RESET_ARM, `OP_RESET_FIRE: ok = 1'b1; // see (RL8)
            `OP_HIBERNATE_ENTRY, `OP_SLEEP_ENTRY,
            `OP_SLEEP_EXIT: ok = 1'b1; // see (RL9)
            `OP_STATUS_READ, `OP_STATUS_WRITE: ok = 1'b1; // see (RL10)
            `OP_CONFIG_READ:  ok = 1'b1; // see (RL11)
            `OP_CONFIG_WRITE: ok = (p != PROTO_FOUR); // see (RL11)
            `OP_IDENT_READ, `OP_FAST_IDENT_READ: ok = 1'b1; // see (RL12)
            `OP_SERIAL_NO_WRITE, `OP_SERIAL_NO_READ,
            `OP_FAST_SERIAL_READ: ok = 1'b1; // see (RL13)
            `OP_NV_SAVE, `OP_NV_RESTORE, `OP_AUTO_SAVE_ENABLE,
            `OP_AUTO_SAVE_DISABLE: ok = 1'b1; // see (RL14)
            `OP_RSVD_0, `OP_RSVD_1, `OP_RSVD_2, `OP_RSVD_3,
            `OP_RSVD_4, `OP_RSVD_5, `OP_RSVD_6: ok = 1'b1; // see (RL15)
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // coarse class handed to the datapath with each opcode
    function automatic cmd_class_type op_class(input logic [7:0] op);
        cmd_class_type c;
        c = CLS_RESERVED;
        case (op)
            `OP_CLEAR_WRITE_LATCH, `OP_SET_WRITE_LATCH, `OP_ENTER_TWO_LANE,
            `OP_ENTER_FOUR_LANE, `OP_ENTER_SINGLE_LANE: c = CLS_CONTROL;
            `OP_READ, `OP_FAST_READ, `OP_DUAL_OUT_READ, `OP_QUAD_OUT_READ,
            `OP_DUAL_AD_READ, `OP_QUAD_AD_READ: c = CLS_READ;
            `OP_WRITE, `OP_DUAL_DATA_WRITE, `OP_QUAD_DATA_WRITE,
            `OP_DUAL_AD_WRITE, `OP_QUAD_AD_WRITE: c = CLS_WRITE;
            `OP_RESET_ARM, `OP_RESET_FIRE, `OP_HIBERNATE_ENTRY,
            `OP_SLEEP_ENTRY, `OP_SLEEP_EXIT: c = CLS_SYSTEM;
            `OP_STATUS_READ, `OP_STATUS_WRITE, `OP_CONFIG_READ,
            `OP_CONFIG_WRITE, `OP_IDENT_READ, `OP_FAST_IDENT_READ,
            `OP_SERIAL_NO_WRITE, `OP_SERIAL_NO_READ,
            `OP_FAST_SERIAL_READ: c = CLS_REGISTER;
            `OP_NV_SAVE, `OP_NV_RESTORE, `OP_AUTO_SAVE_ENABLE,
            `OP_AUTO_SAVE_DISABLE: c = CLS_NV;
            default: c = CLS_RESERVED;
        endcase
        return c;
    endfunction

    // reads that carry a mode byte after the address
    function automatic logic has_mode_byte(input logic [7:0] op);
        return (op == `OP_FAST_READ) || (op == `OP_DUAL_OUT_READ) ||
               (op == `OP_QUAD_OUT_READ) || (op == `OP_DUAL_AD_READ) ||
               (op == `OP_QUAD_AD_READ);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // frame and byte events in the clk domain
    assign frame_start = st_q.cs_prev & ~cs_s; // see (RL2)
    assign frame_end   = ~st_q.cs_prev & cs_s;
    assign byte_ev     = (tog_s != st_q.tog_seen) & ~cs_s;
    // while asleep only the wake code is acted on
    assign accept = op_legal(link_byte, st_q.proto) &&
                    (!st_q.sleep || link_byte == `OP_SLEEP_EXIT);

    ////////////////////////////////////////////////////////////////////////
    // decode and dispatch
    always_comb begin
        st_d            = st_q;
        st_d.cs_prev    = cs_s;
        st_d.tog_seen   = tog_s;
        st_d.cmd_valid  = 1'b0;
        st_d.data_valid = 1'b0;
        st_d.soft_reset = 1'b0;
        st_d.store      = 1'b0;
        st_d.recall     = 1'b0;
        if (frame_start) begin
            // a kept opcode skips index zero and announces itself at once
            st_d.idx       = st_q.xip ? 3'h1 : 3'h0; // see (RL21)
            st_d.ignore    = 1'b0; // see (RL2)
            st_d.hib       = 1'b0;
            st_d.cmd_valid = st_q.xip;
        end
        // lane changes land between frames so no frame switches width
        if (frame_end && st_q.pend_vld) begin
            st_d.proto    = st_q.pend; // see (RL4)
            st_d.pend_vld = 1'b0;
        end
        if (byte_ev && st_q.idx == 3'h0) begin
            st_d.op  = link_byte; // see (RL1) (RL17)
            st_d.idx = 3'h1;
            st_d.arm = 1'b0; // see (RL8)
            if (!accept) begin
                st_d.ignore = 1'b1; // see (RL18) (RL20)
            end else begin
                st_d.cmd_valid = 1'b1;
                st_d.cmd       = '{cls: op_class(link_byte),
                                   opcode: link_byte};
                case (link_byte)
                    `OP_SET_WRITE_LATCH:   st_d.wel = 1'b1; // see (RL3)
                    `OP_CLEAR_WRITE_LATCH: st_d.wel = 1'b0; // see (RL3)
                    `OP_ENTER_TWO_LANE: begin
                        st_d.pend     = PROTO_TWO; // see (RL4)
                        st_d.pend_vld = 1'b1;
                    end
                    `OP_ENTER_FOUR_LANE: begin
                        st_d.pend     = PROTO_FOUR; // see (RL4)
                        st_d.pend_vld = 1'b1;
                    end
                    `OP_ENTER_SINGLE_LANE: begin
                        st_d.pend     = PROTO_SINGLE; // see (RL4)
                        st_d.pend_vld = 1'b1;
                    end
                    `OP_RESET_ARM: st_d.arm = 1'b1; // see (RL8)
                    `OP_RESET_FIRE: begin
                        // only straight after the arm code; repairs config
                        if (st_q.arm) begin
                            st_d.soft_reset = 1'b1; // see (RL8) (RL16)
                            st_d.wel        = 1'b0;
                            st_d.pend       = PROTO_SINGLE; // not mid-frame
                            st_d.pend_vld   = 1'b1;
                            st_d.cfg_bad    = 1'b0;
                            st_d.xip        = 1'b0;
                            st_d.sleep      = 1'b0;
                        end
                    end
                    `OP_HIBERNATE_ENTRY: st_d.hib   = 1'b1; // see (RL9)
                    `OP_SLEEP_ENTRY:     st_d.sleep = 1'b1; // see (RL9)
                    `OP_SLEEP_EXIT:      st_d.sleep = 1'b0; // see (RL9)
                    `OP_NV_SAVE:         st_d.store = 1'b1; // see (RL14)
                    `OP_NV_RESTORE:      st_d.recall = 1'b1; // see (RL14)
                    `OP_AUTO_SAVE_ENABLE:  st_d.autosave = 1'b1;
                    `OP_AUTO_SAVE_DISABLE: st_d.autosave = 1'b0;
                    `OP_RSVD_0, `OP_RSVD_1, `OP_RSVD_2, `OP_RSVD_3,
                    `OP_RSVD_4, `OP_RSVD_5, `OP_RSVD_6:
                        st_d.cfg_bad = 1'b1; // see (RL15)
                    default: st_d.cfg_bad = st_q.cfg_bad;
                endcase
            end
        end else if (byte_ev && !st_q.ignore) begin
            // address, mode and data bytes; dropped after a bad opcode
            st_d.data       = link_byte;
            st_d.data_valid = 1'b1; // see (RL18)
            if (st_q.idx == `MODE_BYTE_IDX && has_mode_byte(st_q.op)) begin
                st_d.xip = (link_byte[7:4] == `XIP_NIBBLE); // see (RL21)
            end
            if (st_q.idx != `LAST_BYTE_IDX) begin
                st_d.idx = st_q.idx + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q          <= '0;
            st_q.cs_prev  <= 1'b1;
            st_q.proto    <= PROTO_SINGLE;
            st_q.pend     <= PROTO_SINGLE;
            st_q.cmd.cls  <= CLS_CONTROL;
            st_q.cmd.opcode <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign cmd          = st_q.cmd;
    assign cmd_valid    = st_q.cmd_valid;
    assign data_byte    = st_q.data;
    assign data_valid   = st_q.data_valid;
    assign proto        = st_q.proto;
    assign write_latch  = st_q.wel;
    assign soft_reset   = st_q.soft_reset;
    assign store_req    = st_q.store;
    assign recall_req   = st_q.recall;
    assign auto_save_en = st_q.autosave;
    assign sleeping     = st_q.sleep;
    assign hibernating  = st_q.hib;
    assign config_bad   = st_q.cfg_bad;
    assign xip_active   = st_q.xip;
    assign out_tristate = st_q.ignore; // see (RL18)

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_opcode_load;
        byte_ev && st_q.idx == 3'h0 |=> st_q.op == $past(link_byte);
    endproperty
    a_opcode_load: assert property (p_opcode_load) // see (RL1)
        else $error("opcode not loaded");

    property p_frame_open;
        frame_start |=> !st_q.ignore && st_q.idx <= 3'h1;
    endproperty
    a_frame_open: assert property (p_frame_open) // see (RL2)
        else $error("frame did not restart");

    property p_latch_set;
        cmd_valid && cmd.opcode == `OP_SET_WRITE_LATCH |-> write_latch;
    endproperty
    a_latch_set: assert property (p_latch_set) // see (RL3)
        else $error("write latch not set");

    property p_latch_clr;
        $fell(write_latch) |-> soft_reset ||
            (cmd_valid && cmd.opcode == `OP_CLEAR_WRITE_LATCH);
    endproperty
    a_latch_clr: assert property (p_latch_clr) // see (RL3)
        else $error("write latch cleared without cause");

    property p_lane_switch;
        frame_end && st_q.pend_vld && st_q.pend == PROTO_FOUR
            |=> proto == PROTO_FOUR;
    endproperty
    a_lane_switch: assert property (p_lane_switch) // see (RL4)
        else $error("four-lane switch missed");

    property p_reset_pair;
        soft_reset |-> $past(st_q.arm, 1) || $past(st_q.arm, 2) ||
            $past(st_q.arm, 3);
    endproperty
    a_reset_pair: assert property (p_reset_pair) // see (RL8)
        else $error("reset without arm");

    property p_reset_effect;
        soft_reset |-> st_q.pend == PROTO_SINGLE && st_q.pend_vld &&
            !write_latch && !config_bad;
    endproperty
    a_reset_effect: assert property (p_reset_effect) // see (RL16)
        else $error("reset left state behind");

    property p_reserved;
        cmd_valid && cmd.cls == CLS_RESERVED |-> config_bad;
    endproperty
    a_reserved: assert property (p_reserved) // see (RL15)
        else $error("reserved code not flagged");

    property p_bad_opcode;
        byte_ev && st_q.idx == 3'h0 && !accept
            |=> out_tristate && !cmd_valid;
    endproperty
    a_bad_opcode: assert property (p_bad_opcode) // see (RL20)
        else $error("illegal opcode dispatched");

    property p_drop_data;
        out_tristate |-> !data_valid;
    endproperty
    a_drop_data: assert property (p_drop_data) // see (RL18)
        else $error("data passed after bad opcode");

    property p_single_only;
        cmd_valid && cmd.opcode == `OP_QUAD_AD_READ && !$past(frame_start)
            |-> proto == PROTO_SINGLE;
    endproperty
    a_single_only: assert property (p_single_only) // see (RL6)
        else $error("multi-lane read outside single lane");

    c_lane_change: cover property (frame_end && st_q.pend_vld);
    c_reset_pair:  cover property (soft_reset);
    c_xip_frame:   cover property (frame_start && st_q.xip);
    c_bad_frame:   cover property ($rose(out_tristate));

endmodule

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    output logic       cs_n,
    output logic       sck,
    output logic [3:0] lane_in
);
    int w = 1; // lanes per beat, set by the bench from its protocol model

    // idle: deselected, serial clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        lane_in = 4'h0;
    end

    // one byte, MSB first, lanes change only while sck is low
    task automatic put(input logic [7:0] b);
        for (int i = 8; i > 0; i -= w) begin
            lane_in = 4'((b >> (i - w)) & ((1 << w) - 1));
            #24 sck = 1'b1;
            #24 sck = 1'b0;
        end
    endtask

    // a frame always opens on a chip-select fall; released lanes flip
    task automatic frame(input logic [7:0] q[$]);
        #13 cs_n = 1'b0;
        #30;
        foreach (q[k]) put(q[k]);
        #20 cs_n = 1'b1;
        lane_in = ~lane_in;
        #150;
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import qspi_decode_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, cs_n, sck, cv, dv, sr, st, rc;
    logic wl, ase, sl, hib, cb, xip, tri_o;
    logic [3:0] lane_in;
    logic [7:0] db, g_op, g_db;
    logic [2:0] g_cl;
    cmd_type cmd;
    proto_type proto;
    int num_errors = 0, samples_checked = 0, ncv, ndv, nsr, nst, nrc, ntr;
    int p = 0, m_wl = 0, m_cb = 0, m_sl = 0, m_as = 0, arm = 0;
    byte unsigned ops[] = '{8'h04, 8'h06, 8'h37, 8'h05, 8'h01, 8'h35, 8'h87,
        8'h9F, 8'h9E, 8'hC2, 8'hC3, 8'hC9, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h03,
        8'h0B, 8'h02, 8'h38, 8'h87, 8'h3B, 8'hFF, 8'h3B, 8'h6B, 8'hBB, 8'hEB,
        8'hA2, 8'h32, 8'hA1, 8'hD2, 8'hC5, 8'h1E, 8'hC8, 8'hCE, 8'hCB, 8'hCC,
        8'hCD, 8'h66, 8'h99, 8'hBA, 8'hB9, 8'h04, 8'hAB};

    always #2 clk = ~clk;
    host_model u_host (.cs_n(cs_n), .sck(sck), .lane_in(lane_in));
    qspi_opcode_decoder u_dut (.clk(clk), .resetn(resetn), .sck(sck),
        .cs_n(cs_n), .lane_in(lane_in), .cmd(cmd), .cmd_valid(cv),
        .data_byte(db), .data_valid(dv), .proto(proto), .write_latch(wl),
        .soft_reset(sr), .store_req(st), .recall_req(rc),
        .auto_save_en(ase), .sleeping(sl), .hibernating(hib),
        .config_bad(cb), .xip_active(xip), .out_tristate(tri_o));

    // pulse counters; tristate only looked at mid-byte, past stale state
    always @(posedge clk) begin
        ncv <= ncv + cv;
        ndv <= ndv + dv;
        nsr <= nsr + sr;
        nst <= nst + st;
        nrc <= nrc + rc;
        ntr <= ntr | (tri_o & sck);
        if (cv) {g_cl, g_op} <= cmd;
        if (dv) g_db <= db;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // legality per protocol; sleep only lets the wake code through
    function automatic bit ok(byte unsigned o);
        if (m_sl) return o == 8'hAB;
        if (!(o inside {ops})) return 0;
        if (o inside {8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hA2, 8'h32, 8'hA1, 8'hD2})
            return p == 0;
        if (o == 8'h37) return p != 1;
        if (o == 8'h38 || o == 8'h87) return p != 2;
        if (o == 8'hFF) return p != 0;
        return 1;
    endfunction

    // one frame of opcode plus data byte against the reference model
    task automatic run(input byte unsigned o, input logic [7:0] d);
        bit a, r, v;
        logic [3:0] e;
        logic [5:0] f;
        a = ok(o);
        r = a && o == 8'h99 && arm;
        v = a && o inside {8'hC5, 8'h1E, 8'hC8, 8'hCE, 8'hCB, 8'hCC, 8'hCD};
        // clear on a falling edge so no counter update races the clear
        @(negedge clk);
        {ncv, ndv, nsr, nst, nrc, ntr, g_op, g_db, g_cl} = 0;
        u_host.w = (p == 0) ? 1 : (p == 1) ? 2 : 4;
        u_host.frame('{o, d});
        if (a) begin
            case (o)
                8'h06: m_wl = 1;
                8'h04: m_wl = 0;
                8'h37: p = 1;
                8'h38: p = 2;
                8'hFF: p = 0;
                8'hB9: m_sl = 1;
                8'hAB: m_sl = 0;
                8'h8E: m_as = 1;
                8'h8F: m_as = 0;
                8'h99: if (r) {p, m_wl, m_cb, m_sl} = 0;
                default: if (v) m_cb = 1;
            endcase
        end
        arm = a && o == 8'h66;
        e = {r, a && o == 8'h8C, a && o == 8'h8D, a && o == 8'hBA};
        f = {2'(p), 1'(m_wl), 1'(m_cb), 1'(m_sl), 1'(m_as)};
        check({g_op, g_db}, a ? {o, d} : 16'h0000);
        check(ncv, a);
        check(ndv, a);
        check(ntr, !a);
        check(g_cl == CLS_RESERVED, v);
        check({1'(nsr), 1'(nst), 1'(nrc), hib}, e);
        check({proto, wl, cb, sl, ase}, f);
    endtask

    // mode-byte frame: xip_active follows the upper nibble, 0Bh is kept
    task automatic xip_run(input logic [7:0] q[$], input bit k);
        @(negedge clk);
        {ncv, ndv, g_op, g_db} = 0;
        u_host.frame(q);
        check({4'(ncv), 4'(ndv), g_op, g_db},
            {8'h14, 8'h0B, q[$]});
        check(xip, k);
    endtask

    // every code in sequence (87h, 3Bh, 04h twice), then a random mix with unknown codes
    initial begin
        void'($urandom(32'h446E926E));
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        foreach (ops[i]) run(ops[i], 8'($urandom));
        $display("table pass done");
        xip_run('{8'h0B, 8'h00, 8'h01, 8'h02, 8'hA5}, 1'b1);
        xip_run('{8'h00, 8'h01, 8'h02, 8'h5A}, 1'b0);
        $display("mode pass done");
        repeat (120) run(($urandom & 3) ? ops[$urandom % ops.size()]
            : 8'($urandom), 8'($urandom));
        $display("random pass done");
        give_verdict;
    end

    // hang guard, well past the expected run time
    initial begin
        #250000;
        num_errors++;
        give_verdict;
    end
endmodule
